// *** core/timer_cc_consts.vh ***
`ifndef TIMER_CC_CONSTS_VH
`define TIMER_CC_CONSTS_VH

// ************************************
// register byte offsets
// ************************************
`define TCC_OFF_CTRL 8'h00
`define TCC_OFF_ENABLE 8'h04
`define TCC_OFF_PORT 8'h08
`define TCC_OFF_FLAGS 8'h0C
`define TCC_OFF_CH0 8'h10
`define TCC_OFF_CH1 8'h14
`define TCC_OFF_CH2 8'h18
`define TCC_OFF_CH3 8'h1C
`define TCC_OFF_TIMER 8'h20

// ************************************
// field positions
// ************************************
`define TCC_CTRL_EDGE_SEL 0
`define TCC_CTRL_CMP_MODE1 1

// ************************************
// channel mode codes
// ************************************
`define TCC_MODE_OFF 2'h0
`define TCC_MODE_CAP_PIN 2'h1
`define TCC_MODE_COMPARE 2'h2
`define TCC_MODE_CAP_WRITE 2'h3

// ************************************
// reset values
// ************************************
`define TCC_RST_CTRL 2'h0
`define TCC_RST_ENABLE 8'h00
`define TCC_RST_PORT 4'hF
`define TCC_RST_CC 16'h0000

// ************************************
// timing and bus answers
// ************************************
`define TCC_MACH_DIV 12
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_DECERR 2'h3

`endif

// *** core/cc_edge_detect.v ***
`timescale 1ns/1ps
`default_nettype none

// ************************************
// one sample per machine cycle, edge in chosen direction
// ************************************
module cc_edge_detect
(
  input wire sys_clk,
  input wire rst_b,
  input wire sampleEn,
  input wire level,
  input wire riseSel,
  output reg edgeSeen
);

  reg prevLevel;

  // idle level of a pulled-up pin is high; avoids a false edge after reset
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prevLevel <= 1'b1;
      edgeSeen <= 1'b0;
    end
    else if (sampleEn)
    begin
      prevLevel <= level;
      edgeSeen <= riseSel ? (level & ~prevLevel) : (~level & prevLevel);
    end
    else
    begin
      edgeSeen <= 1'b0;
    end
  end

endmodule // cc_edge_detect

`default_nettype wire

// *** core/timer_compare_capture_irq.v ***
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - compare mode swaps pin for match signal
// - port reads still return pin levels
// - match drives output and sets request flag
// - compare signal high while count equals register
// - shadow transparent while compare signal active
// - reload channel irq edge by select bit
// - channels one to three irq on rise
// - enabling compare on high pin sets flag only on reload channel with fall select
// - capture latches full 16-bit timer value
// - channels one to three capture rising
// - reload channel capture edge by select
// - sample inputs once per machine cycle
// - pin capture lands next machine cycle
// - pin capture edge sets request flag
// - low byte write triggers capture
// - write capture lands next machine cycle
// - write capture raises no request
// - capture mode chosen per channel
// - two-bit mode field per channel
// - compare match moves shadow to output
`include "timer_cc_consts.vh"

module timer_compare_capture_irq #(
  parameter MACH_DIV = `TCC_MACH_DIV
)
(
  input wire sys_clk,
  input wire rst_b,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] timerValue,
  input wire [3:0] pinIn,
  output reg [3:0] pinOut,
  output reg [3:0] pinOe,
  output reg [3:0] compareSignal,
  output reg [3:0] irqFlag
);

  // ************************************
  // machine cycle divider
  // ************************************
  reg [7:0] machCnt;
  reg machEn;

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      machCnt <= 8'h00;
      machEn <= 1'b0;
    end
    else if (machCnt == MACH_DIV[7:0] - 8'h01)
    begin
      machCnt <= 8'h00;
      machEn <= 1'b1;
    end
    else
    begin
      machCnt <= machCnt + 8'h01;
      machEn <= 1'b0;
    end
  end

  // ************************************
  // pin synchroniser
  // ************************************
  reg [3:0] pinMeta;
  reg [3:0] pinSync;

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinMeta <= 4'hF;
      pinSync <= 4'hF;
    end
    else
    begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

  // ************************************
  // control state
  // ************************************
  reg edgeSelect;
  reg cmpMode1;
  reg [7:0] ccEnable;
  reg [3:0] shadowLatch;
  reg [3:0] outLatch;
  reg [15:0] ccReg [0:3];
  reg [3:0] capPending;

  wire [1:0] chMode [0:3];
  wire [3:0] compareOn;
  wire [3:0] irqSource;
  wire [3:0] riseSel;
  wire [3:0] srcEdge;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : chan
      assign chMode[g] = ccEnable[2 * g + 1:2 * g];
      assign compareOn[g] = (chMode[g] == `TCC_MODE_COMPARE);
      // pin is cut off from the irq path in compare mode
      assign irqSource[g] = compareOn[g] ? compareSignal[g] : pinSync[g];
      if (g == 0)
      begin : rld
        assign riseSel[g] = edgeSelect;
      end
      else
      begin : ccx
        assign riseSel[g] = 1'b1;
      end
      // source swap from a high pin to an idle match is seen as a fall
      cc_edge_detect u_edge (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .sampleEn(machEn),
        .level(irqSource[g]),
        .riseSel(riseSel[g]),
        .edgeSeen(srcEdge[g])
      );
    end
  endgenerate

  // ************************************
  // bus write channel
  // ************************************
  reg awHeld;
  reg wHeld;
  reg [7:0] wrAddr;
  reg [31:0] wrData;
  reg [3:0] wrStrb;

  wire wrFire = awHeld & wHeld & ~s_axi_bvalid;
  wire wrCtrl = wrFire & (wrAddr == `TCC_OFF_CTRL);
  wire wrEnable = wrFire & (wrAddr == `TCC_OFF_ENABLE);
  wire wrPort = wrFire & (wrAddr == `TCC_OFF_PORT);
  wire wrFlags = wrFire & (wrAddr == `TCC_OFF_FLAGS);
  wire wrMapped = (wrAddr <= `TCC_OFF_CH3) & (wrAddr[1:0] == 2'h0);

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TCC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        awHeld <= 1'b1;
        wrAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        wHeld <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrFire)
      begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `TCC_RESP_OKAY : `TCC_RESP_DECERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************
  // control, enable and port registers
  // ************************************
  reg [3:0] next_shadow;

  always @*
  begin
    next_shadow = shadowLatch;
    if (wrPort & wrStrb[0])
    begin
      next_shadow = wrData[3:0];
    end
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {cmpMode1, edgeSelect} <= `TCC_RST_CTRL;
      ccEnable <= `TCC_RST_ENABLE;
      shadowLatch <= `TCC_RST_PORT;
    end
    else
    begin
      if (wrCtrl & wrStrb[0])
      begin
        edgeSelect <= wrData[`TCC_CTRL_EDGE_SEL];
        cmpMode1 <= wrData[`TCC_CTRL_CMP_MODE1];
      end
      if (wrEnable & wrStrb[0])
      begin
        ccEnable <= wrData[7:0];
      end
      shadowLatch <= next_shadow;
    end
  end

  // ************************************
  // compare signal and output latches
  // ************************************
  integer i;

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      compareSignal <= 4'h0;
      outLatch <= `TCC_RST_PORT;
      pinOut <= `TCC_RST_PORT;
      pinOe <= 4'h0;
    end
    else
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        compareSignal[i] <= compareOn[i] & (timerValue == ccReg[i]);
        // with compare mode and cmpMode1, shadow only reaches the pin on a match, and follows it while active
        if (!(compareOn[i] & cmpMode1) | compareSignal[i])
        begin
          outLatch[i] <= next_shadow[i];
        end
        pinOut[i] <= outLatch[i];
        // quasi-bidirectional: outside compare mode a latch of one leaves the pin to the outside
        pinOe[i] <= compareOn[i] | ~outLatch[i];
      end
    end
  end

  // ************************************
  // request flags, set wins over clear
  // ************************************
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irqFlag <= 4'h0;
    end
    else
    begin
      // only source edges set flags, so write captures stay silent
      irqFlag <= (irqFlag & ~((wrFlags & wrStrb[0]) ? wrData[3:0] : 4'h0)) | srcEdge;
    end
  end

  // ************************************
  // capture and channel registers
  // ************************************
  reg [3:0] capTrigger;
  reg [3:0] wrChan;
  // each process walks its own index so none shares a driver
  integer j;
  integer k;

  always @*
  begin
    for (j = 0; j < 4; j = j + 1)
    begin
      wrChan[j] = wrFire & (wrAddr == (`TCC_OFF_CH0 + j[5:0] * 6'h04));
      capTrigger[j] = ((ccEnable[2 * j +: 2] == `TCC_MODE_CAP_PIN) & srcEdge[j])
        | ((ccEnable[2 * j +: 2] == `TCC_MODE_CAP_WRITE) & wrChan[j] & wrStrb[0]);
    end
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      capPending <= 4'h0;
      for (k = 0; k < 4; k = k + 1)
      begin
        ccReg[k] <= `TCC_RST_CC;
      end
    end
    else
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        capPending[k] <= capTrigger[k] | (capPending[k] & ~machEn);
        if (capPending[k] & machEn)
        begin
          ccReg[k] <= timerValue;
        end
        else if (wrChan[k])
        begin
          if (wrStrb[0])
          begin
            ccReg[k][7:0] <= wrData[7:0];
          end
          if (wrStrb[1])
          begin
            ccReg[k][15:8] <= wrData[15:8];
          end
        end
      end
    end
  end

  // ************************************
  // bus read channel
  // ************************************
  reg [31:0] rdValue;
  reg rdHit;

  always @*
  begin
    rdValue = 32'h0000_0000;
    rdHit = 1'b1;
    case (s_axi_araddr)
      `TCC_OFF_CTRL: rdValue[1:0] = {cmpMode1, edgeSelect};
      `TCC_OFF_ENABLE: rdValue[7:0] = ccEnable;
      `TCC_OFF_PORT: rdValue[11:0] = {shadowLatch, outLatch, pinSync};
      `TCC_OFF_FLAGS: rdValue[3:0] = irqFlag;
      `TCC_OFF_CH0: rdValue[15:0] = ccReg[0];
      `TCC_OFF_CH1: rdValue[15:0] = ccReg[1];
      `TCC_OFF_CH2: rdValue[15:0] = ccReg[2];
      `TCC_OFF_CH3: rdValue[15:0] = ccReg[3];
      `TCC_OFF_TIMER: rdValue[15:0] = timerValue;
      default: rdHit = 1'b0;
    endcase
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TCC_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdValue;
      s_axi_rresp <= rdHit ? `TCC_RESP_OKAY : `TCC_RESP_DECERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // timer_compare_capture_irq

`default_nettype wire

// *** verification/timer_compare_capture_irq_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****
// bus and event checks
// ****
module timer_compare_capture_irq_checker #(
  parameter MACH_DIV = 12
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] timerValue,
  input wire logic [3:0] pinOe,
  input wire logic [3:0] compareSignal,
  input wire logic [3:0] irqFlag
);
  wire logic wTake;
  assign wTake = (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // detector samples once per machine cycle, flag follows one cycle later
  localparam int IRQ_WAIT = 2 * MACH_DIV + 2;
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  wresp_cause_a: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
    else $error("write response without request");
  rresp_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read data without request");
  cmp_drive_a: assert property ((compareSignal & ~pinOe) == 4'h0)
    else $error("compare active on undriven pin");
  cmp_irq_a: assert property ($rose(compareSignal[1]) ##1 compareSignal[1] |-> ##[0:IRQ_WAIT] irqFlag[1])
    else $error("compare rise set no flag");
  // flags are sticky: only a bus write may clear one
  flag_hold_a: assert property (|($past(irqFlag) & ~irqFlag) |-> $past(wTake) || $past(wTake, 2))
    else $error("flag cleared without write");
  cmp_cause_a: assert property ($changed(compareSignal) |->
    $past(timerValue) != $past(timerValue, 2) || $past(wTake) || $past(wTake, 2) || $past(wTake, 3))
    else $error("compare moved without cause");
endmodule // timer_compare_capture_irq_checker

`default_nettype wire

// *** verification/pin_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****
// port pins with pull-ups and outside drivers
// ****
module pin_source_model
(
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  input wire logic [3:0] extLevel,
  output logic [3:0] pinIn
);
  // wired-and: either side pulling low wins, released pins float high
  assign pinIn = extLevel & (~pinOe | pinOut);
endmodule // pin_source_model

`default_nettype wire

// *** verification/test_timer_compare_capture_irq.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "timer_cc_consts.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module test_timer_compare_capture_irq;
  localparam int MD = 2;
  logic sys_clk = 1'h0, rst_b = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv, lfsr = 32'hF251;
  logic [3:0] s_axi_wstrb = 4'hF, extLevel = 4'hF, pinIn, pinOut, pinOe, compareSignal, irqFlag;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, rb;
  logic [15:0] timerValue = 16'h0000, c;
  int fails = 0, tests_run = 0;

  always #5 sys_clk = ~sys_clk;
  timer_compare_capture_irq #(.MACH_DIV(MD)) u_dut (.*);
  pin_source_model u_pins (.*);

  // ****
  // helpers
  // ****
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] modes(input int ch, input logic [1:0] m);
    return {30'h0, m} << (2 * ch);
  endfunction

  task automatic wrap_up;
    $display("compares %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic guard(input int n);
    if (n >= 40)
    begin
      fails++;
      wrap_up();
    end
  endtask

  task automatic idle(input int n);
    repeat (n * MD) @(posedge sys_clk);
  endtask

  // response ready is held off one cycle, so it rises together with bvalid and never stalls it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (!(s_axi_bvalid && s_axi_bready)) s_axi_bready <= (n > 1);
    end
    while (!(s_axi_bvalid && s_axi_bready) && n < 40);
    rb = s_axi_bresp;
    s_axi_bready <= 1'h0;
    guard(n);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (!(s_axi_rvalid && s_axi_rready)) s_axi_rready <= (n > 1);
    end
    while (!(s_axi_rvalid && s_axi_rready) && n < 40);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
    guard(n);
  endtask

  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'h1;
    @(posedge sys_clk);
    rd(`TCC_OFF_PORT);
    `CHK("port", 32'hFFF, rv)
    rd(8'h24);
    `CHK("decerr", `TCC_RESP_DECERR, rr)
    wr(`TCC_OFF_TIMER, 32'h0);
    `CHK("wdecerr", `TCC_RESP_DECERR, rb)
    $display("test reset done");
    wr(`TCC_OFF_ENABLE, modes(1, `TCC_MODE_CAP_WRITE) | modes(2, `TCC_MODE_CAP_PIN));
    `CHK("wokay", `TCC_RESP_OKAY, rb)
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nxt(lfsr);
      timerValue <= lfsr[15:0];
      wr(`TCC_OFF_CH1, lfsr >> 16);
      idle(2);
      rd(`TCC_OFF_CH1);
      `CHK("wcap", {16'h0, lfsr[15:0]}, rv)
    end
    rd(`TCC_OFF_FLAGS);
    `CHK("noflag", 32'h0, rv)
    wr(`TCC_OFF_PORT, 32'hF);
    extLevel[2] <= 1'h0;
    idle(3);
    rd(`TCC_OFF_CH2);
    `CHK("nofall", 32'h0, rv)
    lfsr = nxt(lfsr);
    timerValue <= lfsr[15:0];
    extLevel[2] <= 1'h1;
    idle(4);
    rd(`TCC_OFF_CH2);
    `CHK("pcap", {16'h0, lfsr[15:0]}, rv)
    rd(`TCC_OFF_FLAGS);
    `CHK("pflag", 32'h4, rv)
    $display("test capture done");
    wr(`TCC_OFF_ENABLE, modes(0, `TCC_MODE_CAP_PIN));
    for (int es = 0; es < 2; es++)
    begin
      wr(`TCC_OFF_CTRL, es);
      idle(3);
      wr(`TCC_OFF_FLAGS, 32'hF);
      lfsr = nxt(lfsr);
      timerValue <= lfsr[15:0];
      extLevel[0] <= es[0];
      idle(4);
      rd(`TCC_OFF_CH0);
      `CHK("cap0", {16'h0, lfsr[15:0]}, rv)
      rd(`TCC_OFF_FLAGS);
      `CHK("flag0", 32'h1, rv)
    end
    $display("test edge select done");
    wr(`TCC_OFF_CTRL, 32'h0);
    lfsr = nxt(lfsr);
    c = lfsr[15:0];
    timerValue <= ~c;
    wr(`TCC_OFF_CH0, c);
    wr(`TCC_OFF_CH1, c);
    wr(`TCC_OFF_FLAGS, 32'hF);
    wr(`TCC_OFF_ENABLE, modes(0, `TCC_MODE_COMPARE) | modes(1, `TCC_MODE_COMPARE));
    idle(3);
    rd(`TCC_OFF_FLAGS);
    `CHK("armflag", 32'h1, rv)
    wr(`TCC_OFF_FLAGS, 32'hF);
    timerValue <= c;
    extLevel <= 4'hC;
    idle(3);
    `CHK("cmpon", 4'h3, compareSignal)
    rd(`TCC_OFF_PORT);
    `CHK("pinlvl", 4'hC, rv[3:0])
    rd(`TCC_OFF_FLAGS);
    `CHK("riseflag", 32'h2, rv)
    timerValue <= ~c;
    extLevel <= 4'hF;
    idle(3);
    `CHK("cmpoff", 4'h0, compareSignal)
    rd(`TCC_OFF_FLAGS);
    `CHK("fallflag", 32'h3, rv)
    $display("test compare done");
    wr(`TCC_OFF_CTRL, 32'h2);
    wr(`TCC_OFF_PORT, 32'hD);
    rd(`TCC_OFF_PORT);
    `CHK("held", 4'hF, rv[7:4])
    timerValue <= c;
    idle(3);
    rd(`TCC_OFF_PORT);
    `CHK("moved", 4'hD, rv[7:4])
    `CHK("pindrv", 4'hD, pinOut)
    `CHK("pinoe", 4'h3, pinOe)
    wr(`TCC_OFF_PORT, 32'hF);
    rd(`TCC_OFF_PORT);
    `CHK("transp", 4'hF, rv[7:4])
    timerValue <= ~c;
    $display("test shadow done");
    wrap_up();
  end
endmodule // test_timer_compare_capture_irq

bind timer_compare_capture_irq timer_compare_capture_irq_checker #(.MACH_DIV(MACH_DIV)) u_chk (.*);

`default_nettype wire
